// ### hdl/nvm_pkg.sv
// Constants and types shared by the nonvolatile block memory controller
package nvm_pkg;
  // ==========================================================
  // Array organisation
  localparam int PAGE_BYTES    = 128;
  localparam int PAGES_PER_SEC = 33;
  localparam int SECTORS       = 64;
  localparam int BLK_BITS      = 128;
  localparam int BLKS_PER_PAGE = 8;
  localparam int CHK_BITS      = 9;
  localparam int ADDR_W        = 19;
  localparam int PAGE_W        = 12;
  localparam int BLK_W         = 15;
  localparam int SEC_W         = 6;
  localparam int TOTAL_BYTES   = PAGE_BYTES * PAGES_PER_SEC * SECTORS;
  localparam int NUM_BLKS      = TOTAL_BYTES / (BLK_BITS / 8);
  // ==========================================================
  // Timing, longest times rounded down to whole cycles
  localparam int CLK_PERIOD_PS = 5000;
  localparam int T_RAND_NS     = 60;
  localparam int T_RA_NS       = 10;
  localparam int RAND_CYC      = T_RAND_NS * 1000 / CLK_PERIOD_PS;
  localparam int RA_CYC        = T_RA_NS * 1000 / CLK_PERIOD_PS;
  // ==========================================================
  // Port width codes and operations
  localparam logic [1:0] W8  = 2'h0;
  localparam logic [1:0] W16 = 2'h1;
  localparam logic [1:0] W32 = 2'h2;
  localparam logic [BLK_BITS-1:0] ERASED_BLK = {BLK_BITS{1'b1}};
  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_WRITE = 2'h1,
    OP_PROG  = 2'h2,
    OP_ERASE = 2'h3
  } op_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_WAIT = 4'b0010,
    S_LOAD = 4'b0100,
    S_PROG = 4'b1000
  } state_t;
endpackage : nvm_pkg

// ### hdl/ecc_if.sv
// Encoder and decoder signals between controller and ECC engine
`timescale 1ns/1ps
interface ecc_if;
  logic [127:0] enc_data;
  logic [8:0]   enc_chk;
  logic [127:0] dec_data;
  logic [8:0]   dec_chk;
  logic [127:0] cor_data;
  logic         sbe;
  logic         dbe;
  modport ctrl   (output enc_data, dec_data, dec_chk,
                  input enc_chk, cor_data, sbe, dbe);
  modport engine (input enc_data, dec_data, dec_chk,
                  output enc_chk, cor_data, sbe, dbe);
endinterface : ecc_if

// ### hdl/nvm_ecc.sv
// SECDED engine: extended Hamming code over one 128-bit data block
`timescale 1ns/1ps
module nvm_ecc (
  ecc_if.engine e
);
  // ==========================================================
  // Code helpers
  // Codeword position of data bit i; powers of two hold check bits
  function automatic logic [7:0] hpos(input int i);
    int n;
    int p;
    logic [7:0] r;
    n = 0;
    r = 8'h00;
    for (p = 1; p < 137; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (n == i) r = p[7:0];
        n++;
      end
    end
    return r;
  endfunction : hpos

  // XOR of positions of all set data bits
  function automatic logic [7:0] syn(input logic [127:0] d);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 128; i++) begin
      if (d[i]) s = s ^ hpos(i);
    end
    return s;
  endfunction : syn

  // ==========================================================
  // Encoder: eight Hamming bits plus overall parity on top
  always_comb begin
    e.enc_chk[7:0] = syn(e.enc_data);
    e.enc_chk[8]   = ^e.enc_data ^ ^e.enc_chk[7:0];
  end

  // Decoder: odd overall parity means one flip, fixable
  always_comb begin
    logic [7:0] s;
    logic       ov;
    s  = e.dec_chk[7:0] ^ syn(e.dec_data);
    ov = ^e.dec_data ^ ^e.dec_chk;
    e.cor_data = e.dec_data;
    for (int i = 0; i < 128; i++) begin
      if (ov && hpos(i) == s) e.cor_data[i] = ~e.dec_data[i];
    end
    e.sbe = ov;
    e.dbe = !ov && (s != 8'h00);
  end
endmodule : nvm_ecc

// ### hdl/nvm_block.sv
// Controller for one nonvolatile memory block with its parallel port
`timescale 1ns/1ps
module nvm_block #(
  // Whitening key for the serial path; value is arbitrary
  parameter logic [127:0] XKEY = 128'h5a5a_0f0f_c3c3_1234_8765_a5a5_f0f0_3c3c
) (
  input  logic        mclk,
  input  logic        sys_rst,
  input  logic        clk_en,
  input  logic [1:0]  cfg_width,
  input  logic        ra_en,
  input  logic        prot_all,
  input  logic [63:0] prot_sector,
  input  logic        req_valid,
  input  logic [1:0]  req_op,
  input  logic [18:0] req_addr,
  input  logic [31:0] req_wdata,
  input  logic        jtag_valid,
  input  logic [14:0] jtag_blk,
  input  logic [127:0] jtag_cipher,
  output logic        req_ready_q,
  output logic        rsp_valid_q,
  output logic        rsp_err_q,
  output logic [31:0] rsp_rdata_q,
  output logic        rsp_sbe_q,
  output logic        rsp_dbe_q
);
  // ==========================================================
  // Helpers
  function automatic logic [5:0] sector_of(input logic [11:0] pg);
    return 6'(pg / nvm_pkg::PAGES_PER_SEC);
  endfunction : sector_of

  // Narrow data sits in the low bits, aligned to its own size
  function automatic logic [31:0] lane_rd(input logic [127:0] b,
      input logic [3:0] o, input logic [1:0] w);
    logic [31:0] r;
    case (w)
      nvm_pkg::W8:  r = {24'h00_0000, b[{o, 3'b000} +: 8]};
      nvm_pkg::W16: r = {16'h0000, b[{o[3:1], 4'b0000} +: 16]};
      default:      r = b[{o[3:2], 5'b00000} +: 32];
    endcase
    return r;
  endfunction : lane_rd

  function automatic logic [127:0] lane_wr(input logic [127:0] b,
      input logic [3:0] o, input logic [1:0] w, input logic [31:0] d);
    logic [127:0] r;
    r = b;
    case (w)
      nvm_pkg::W8:  r[{o, 3'b000} +: 8] = d[7:0];
      nvm_pkg::W16: r[{o[3:1], 4'b0000} +: 16] = d[15:0];
      default:      r[{o[3:2], 5'b00000} +: 32] = d;
    endcase
    return r;
  endfunction : lane_wr

  // ==========================================================
  // State
  localparam logic [18:0] TOP_ADDR = 19'(nvm_pkg::TOTAL_BYTES);
  localparam logic [14:0] TOP_BLK  = 15'(nvm_pkg::NUM_BLKS);
  localparam logic [3:0]  RAND_N   = 4'(nvm_pkg::RAND_CYC - 1);
  localparam logic [3:0]  RA_N     = 4'(nvm_pkg::RA_CYC - 1);

  logic [136:0]         mem_q [nvm_pkg::NUM_BLKS];
  logic [127:0]         pb_q [nvm_pkg::BLKS_PER_PAGE];
  logic                 pb_valid_q;
  logic [11:0]          pb_page_q;
  logic [127:0]         bb_q;
  logic [14:0]          bb_tag_q;
  logic                 bb_valid_q;
  logic                 bb_dbe_q;
  nvm_pkg::state_t      st_q;
  logic [3:0]           cnt_q;
  logic [2:0]           idx_q;
  logic [18:0]          addr_q;
  logic [31:0]          wdata_q;
  logic [1:0]           w_q;
  logic                 hit_q;
  logic                 erase_q;

  ecc_if ecc ();
  nvm_ecc u_ecc (
    .e (ecc.engine)
  );

  // ==========================================================
  // Request decode
  logic [11:0] page;
  logic [11:0] prog_page;
  logic [11:0] req_page;
  logic        req_bad;
  logic        hit_now;
  logic        go;
  logic        jt_go;
  logic        jt_bad;
  logic [127:0] jt_plain;
  logic [14:0] dblk;

  // Page, sector and offset from the byte address
  assign page      = req_addr[18:7];
  assign req_page  = (req_op == nvm_pkg::OP_PROG) ? pb_page_q : page;
  assign prog_page = erase_q ? addr_q[18:7] : pb_page_q;
  // Range, lock and empty-buffer refusals
  assign req_bad = (req_op != nvm_pkg::OP_PROG && req_addr >= TOP_ADDR)
      || (req_op != nvm_pkg::OP_READ
          && (prot_all || prot_sector[sector_of(req_page)]))
      || (req_op == nvm_pkg::OP_PROG && !pb_valid_q);
  // Fast path only on a buffered block in read-ahead mode
  assign hit_now = ra_en && bb_valid_q && bb_tag_q == req_addr[18:4];
  assign go      = clk_en && req_ready_q && req_valid;
  // Serial path yields to the parallel port when both ask
  assign jt_go   = clk_en && req_ready_q && !req_valid && jtag_valid;
  assign jt_bad  = jtag_blk >= TOP_BLK || prot_all
      || prot_sector[sector_of(jtag_blk[14:3])];
  // Keyed, address-tweaked unwrap; a light stand-in, not full AES
  assign jt_plain = jtag_cipher ^ XKEY ^ {8{1'b0, jtag_blk}};

  // ECC sources: page load walks blocks, reads use latched address
  assign dblk = (st_q == nvm_pkg::S_LOAD) ? {addr_q[18:7], idx_q}
                                          : addr_q[18:4];
  assign ecc.dec_data = mem_q[dblk][127:0];
  assign ecc.dec_chk  = mem_q[dblk][136:128];
  assign ecc.enc_data = (st_q == nvm_pkg::S_PROG)
      ? (erase_q ? nvm_pkg::ERASED_BLK : pb_q[idx_q]) : jt_plain;

  // ==========================================================
  // Sequencer and response
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q        <= nvm_pkg::S_IDLE;
      req_ready_q <= 1'b1;
      rsp_valid_q <= 1'b0;
      rsp_err_q   <= 1'b0;
      rsp_rdata_q <= 32'h0000_0000;
      rsp_sbe_q   <= 1'b0;
      rsp_dbe_q   <= 1'b0;
      cnt_q       <= 4'h0;
      idx_q       <= 3'h0;
      addr_q      <= 19'h0_0000;
      wdata_q     <= 32'h0000_0000;
      w_q         <= 2'h0;
      hit_q       <= 1'b0;
      erase_q     <= 1'b0;
    end else if (clk_en) begin
      rsp_valid_q <= 1'b0;
      unique case (st_q)
        nvm_pkg::S_IDLE: begin
          if (go) begin
            addr_q  <= req_addr;
            wdata_q <= req_wdata;
            w_q     <= cfg_width;
            idx_q   <= 3'h0;
            erase_q <= req_op == nvm_pkg::OP_ERASE;
            hit_q   <= hit_now;
            rsp_err_q <= req_bad;
            rsp_sbe_q <= 1'b0;
            rsp_dbe_q <= 1'b0;
            rsp_rdata_q <= 32'h0000_0000;
            if (req_bad) begin
              rsp_valid_q <= 1'b1;
            end else if (req_op == nvm_pkg::OP_READ) begin
              cnt_q       <= hit_now ? RA_N : RAND_N;
              st_q        <= nvm_pkg::S_WAIT;
              req_ready_q <= 1'b0;
            end else if (req_op == nvm_pkg::OP_WRITE) begin
              if (pb_valid_q && pb_page_q == page) begin
                rsp_valid_q <= 1'b1;
              end else begin
                st_q        <= nvm_pkg::S_LOAD;
                req_ready_q <= 1'b0;
              end
            end else begin
              st_q        <= nvm_pkg::S_PROG;
              req_ready_q <= 1'b0;
            end
          end else if (jt_go) begin
            rsp_valid_q <= 1'b1;
            rsp_err_q   <= jt_bad;
            rsp_sbe_q   <= 1'b0;
            rsp_dbe_q   <= 1'b0;
            rsp_rdata_q <= 32'h0000_0000;
          end
        end
        nvm_pkg::S_WAIT: begin
          if (cnt_q == 4'h0) begin
            rsp_valid_q <= 1'b1;
            rsp_rdata_q <= lane_rd(hit_q ? bb_q : ecc.cor_data,
                                   addr_q[3:0], w_q);
            rsp_sbe_q   <= hit_q ? 1'b0 : ecc.sbe;
            rsp_dbe_q   <= hit_q ? bb_dbe_q : ecc.dbe;
            st_q        <= nvm_pkg::S_IDLE;
            req_ready_q <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: begin
          // Page load and page program both walk eight blocks
          idx_q <= idx_q + 3'h1;
          if (idx_q == 3'h7) begin
            rsp_valid_q <= 1'b1;
            st_q        <= nvm_pkg::S_IDLE;
            req_ready_q <= 1'b1;
          end
        end
      endcase
    end
  end

  // Page buffer: merge in place, or fill then merge on a miss
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pb_valid_q <= 1'b0;
      pb_page_q  <= 12'h000;
    end else if (clk_en) begin
      if (go && !req_bad && req_op == nvm_pkg::OP_WRITE) begin
        if (pb_valid_q && pb_page_q == page) begin
          pb_q[req_addr[6:4]] <= lane_wr(pb_q[req_addr[6:4]],
              req_addr[3:0], cfg_width, req_wdata);
        end else begin
          pb_valid_q <= 1'b0;
          pb_page_q  <= page;
        end
      end else if (st_q == nvm_pkg::S_LOAD) begin
        pb_q[idx_q] <= (idx_q == addr_q[6:4])
            ? lane_wr(ecc.cor_data, addr_q[3:0], w_q, wdata_q)
            : ecc.cor_data;
        if (idx_q == 3'h7) pb_valid_q <= 1'b1;
      end else if (st_q == nvm_pkg::S_PROG && erase_q && idx_q == 3'h7
                   && prog_page == pb_page_q) begin
        pb_valid_q <= 1'b0;
      end
    end
  end

  // Block buffer keeps the last fetched block; any program drops it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bb_valid_q <= 1'b0;
      bb_dbe_q   <= 1'b0;
      bb_tag_q   <= 15'h0000;
      bb_q       <= 128'h0;
    end else if (clk_en) begin
      if (st_q == nvm_pkg::S_WAIT && cnt_q == 4'h0 && !hit_q) begin
        bb_q       <= ecc.cor_data;
        bb_tag_q   <= addr_q[18:4];
        bb_dbe_q   <= ecc.dbe;
        bb_valid_q <= 1'b1;
      end else if (st_q == nvm_pkg::S_PROG || (jt_go && !jt_bad)) begin
        bb_valid_q <= 1'b0;
      end
    end
  end

  // Array writes, each block stored with its check bits
  always_ff @(posedge mclk) begin
    if (clk_en) begin
      if (st_q == nvm_pkg::S_PROG) begin
        mem_q[{prog_page, idx_q}] <= {ecc.enc_chk, ecc.enc_data};
      end else if (jt_go && !jt_bad) begin
        mem_q[jtag_blk] <= {ecc.enc_chk, jt_plain};
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic acc_rd;
  assign acc_rd = go && !req_bad && req_op == nvm_pkg::OP_READ;

  rand_lat_a: assert property (
    acc_rd && !hit_now ##1 clk_en[*8] ##1 clk_en[*4] |=> rsp_valid_q)
    else $error("random read latency wrong");
  rand_early_a: assert property (
    acc_rd && !hit_now |=> !rsp_valid_q[*8])
    else $error("random read answered early");
  ra_lat_a: assert property (
    acc_rd && hit_now ##1 clk_en[*2] |=> rsp_valid_q && !rsp_err_q)
    else $error("read-ahead latency wrong");
  dbe_flag_a: assert property (
    st_q == nvm_pkg::S_WAIT && cnt_q == 4'h0 && clk_en && !hit_q
    && ecc.dbe |=> rsp_valid_q && rsp_dbe_q)
    else $error("double error not flagged");
  lock_refuse_a: assert property (
    go && req_op != nvm_pkg::OP_READ
    && (prot_all || prot_sector[sector_of(req_page)])
    |=> rsp_valid_q && rsp_err_q && req_ready_q)
    else $error("locked region not refused");
  range_err_a: assert property (
    go && req_op == nvm_pkg::OP_READ && req_addr >= TOP_ADDR
    |=> rsp_valid_q && rsp_err_q)
    else $error("out of range read accepted");
  jtag_prog_a: assert property (
    jt_go && !jt_bad |=> mem_q[$past(jtag_blk)][127:0] == $past(jt_plain))
    else $error("serial block not stored");
  bb_fill_a: assert property (
    st_q == nvm_pkg::S_WAIT && cnt_q == 4'h0 && clk_en && !hit_q
    |=> bb_valid_q && bb_q == $past(ecc.cor_data))
    else $error("block buffer not filled");
  ecc_clean_a: assert property (
    !ecc.sbe && !ecc.dbe |-> ecc.cor_data == ecc.dec_data)
    else $error("clean block altered");
  narrow_rd_a: assert property (
    $rose(rsp_valid_q) && st_q == nvm_pkg::S_IDLE && w_q == nvm_pkg::W8
    && $past(st_q) == nvm_pkg::S_WAIT |-> rsp_rdata_q[31:8] == 24'h00_0000)
    else $error("byte read upper bits set");
  load_len_a: assert property (
    st_q == nvm_pkg::S_LOAD && clk_en && idx_q == 3'h7
    |=> st_q == nvm_pkg::S_IDLE && pb_valid_q)
    else $error("page load length wrong");

  miss_read_c: cover property (acc_rd && !hit_now);
  hit_read_c: cover property (acc_rd && hit_now);
  page_prog_c: cover property (st_q == nvm_pkg::S_PROG && idx_q == 3'h7);
  jtag_ok_c: cover property (jt_go && !jt_bad);
endmodule : nvm_block

// ### tb/fabric_requester.sv
// Requester model for the parallel port and the serial programming path
`timescale 1ns/1ps
module fabric_requester (
  input  wire logic         mclk,
  input  wire logic         req_ready_q,
  input  wire logic         rsp_valid_q,
  input  wire logic         rsp_err_q,
  input  wire logic [31:0]  rsp_rdata_q,
  input  wire logic         rsp_dbe_q,
  output logic              req_valid,
  output logic [1:0]        req_op,
  output logic [1:0]        cfg_width,
  output logic [18:0]       req_addr,
  output logic [31:0]       req_wdata,
  output logic              jtag_valid,
  output logic [14:0]       jtag_blk,
  output logic [127:0]      jtag_cipher
);
  // ==========================================================
  // Idle port at time zero, nothing requested
  initial begin
    req_valid   = 1'b0;
    req_op      = 2'h0;
    cfg_width   = 2'h2;
    req_addr    = 19'h0_0000;
    req_wdata   = 32'h0000_0000;
    jtag_valid  = 1'b0;
    jtag_blk    = 15'h0000;
    jtag_cipher = 128'h0;
  end

  // ==========================================================
  // Count edges up to the answer pulse; bounded so a hang cannot stall
  task automatic await_rsp(output logic [31:0] rd, output logic err,
                           output logic dbe, output int lat);
    int n;
    n = 0;
    // Caller stands on the taking edge; a refusal shows right after it
    #1;
    while (rsp_valid_q !== 1'b1 && n < 40) begin
      @(posedge mclk);
      #1;
      n++;
    end
    rd  = rsp_rdata_q;
    err = rsp_err_q;
    dbe = rsp_dbe_q;
    lat = (rsp_valid_q === 1'b1) ? n : -1;
  endtask : await_rsp

  // Parallel request, held until the edge that sees ready high
  task automatic xfer(input logic [1:0] op, input logic [18:0] addr,
                      input logic [31:0] wd, input logic [1:0] w,
                      output logic [31:0] rd, output logic err,
                      output logic dbe, output int lat);
    int n;
    n = 0;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_op    <= op;
    req_addr  <= addr;
    req_wdata <= wd;
    cfg_width <= w;
    do begin
      @(posedge mclk);
      n++;
    end while (req_ready_q !== 1'b1 && n < 40);
    // Released address and write data show the inverse, never a stale copy
    req_valid <= 1'b0;
    req_addr  <= ~addr;
    req_wdata <= ~wd;
    await_rsp(rd, err, dbe, lat);
  endtask : xfer

  // Serial block transfer; parallel side stays quiet meanwhile
  task automatic jx(input logic [14:0] blk, input logic [127:0] cipher,
                    output logic [31:0] rd, output logic err,
                    output logic dbe, output int lat);
    int n;
    n = 0;
    @(posedge mclk);
    jtag_valid  <= 1'b1;
    jtag_blk    <= blk;
    jtag_cipher <= cipher;
    // Held until the edge that sees the port idle
    do begin
      @(posedge mclk);
      n++;
    end while (req_ready_q !== 1'b1 && n < 40);
    jtag_valid  <= 1'b0;
    jtag_blk    <= ~blk;
    jtag_cipher <= ~cipher;
    await_rsp(rd, err, dbe, lat);
  endtask : jx
endmodule : fabric_requester

// ### tb/tb_top.sv
// Self-checking testbench for the nonvolatile block memory controller
`timescale 1ns/1ps
module tb_top;
  // Whitening key for this run; value is arbitrary
  localparam logic [127:0] KEY = 128'h1111_2222_3333_4444_5555_6666_7777_8888;
  localparam logic [127:0] PLAIN =
      128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0;

  logic          mclk = 1'b0;
  logic          sys_rst = 1'b1;
  logic          clk_en = 1'b1;
  logic          ra_en = 1'b0;
  logic          prot_all = 1'b0;
  logic [63:0]   prot_sector = 64'h0;
  logic          req_valid, jtag_valid;
  logic [1:0]    req_op, cfg_width;
  logic [18:0]   req_addr;
  logic [31:0]   req_wdata, rsp_rdata_q;
  logic [14:0]   jtag_blk;
  logic [127:0]  jtag_cipher;
  logic          req_ready_q, rsp_valid_q, rsp_err_q, rsp_sbe_q, rsp_dbe_q;
  int            n_mismatch = 0;
  int            n_checks = 0;

  // ==========================================================
  // Clock at 200 MHz
  always #2.5 mclk = ~mclk;

  nvm_block #(.XKEY(KEY)) i_nvm_block (
    .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .cfg_width(cfg_width),
    .ra_en(ra_en), .prot_all(prot_all), .prot_sector(prot_sector),
    .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
    .req_wdata(req_wdata), .jtag_valid(jtag_valid), .jtag_blk(jtag_blk),
    .jtag_cipher(jtag_cipher), .req_ready_q(req_ready_q),
    .rsp_valid_q(rsp_valid_q), .rsp_err_q(rsp_err_q),
    .rsp_rdata_q(rsp_rdata_q), .rsp_sbe_q(rsp_sbe_q), .rsp_dbe_q(rsp_dbe_q));

  fabric_requester i_fabric_requester (
    .mclk(mclk), .req_ready_q(req_ready_q), .rsp_valid_q(rsp_valid_q),
    .rsp_err_q(rsp_err_q), .rsp_rdata_q(rsp_rdata_q), .rsp_dbe_q(rsp_dbe_q),
    .req_valid(req_valid), .req_op(req_op), .cfg_width(cfg_width),
    .req_addr(req_addr), .req_wdata(req_wdata), .jtag_valid(jtag_valid),
    .jtag_blk(jtag_blk), .jtag_cipher(jtag_cipher));

  // ==========================================================
  // Comparison and verdict
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // A missing answer ends the run; data is judged only when accepted
  task automatic judge(input logic [31:0] rd, input logic err, dbe,
                       input int lat, input logic rd_op, chk_rd, e_err,
                       input int e_lat, input logic [31:0] e_rd);
    if (lat < 0) begin
      n_mismatch++;
      $display("Error answer expected pulse seen none");
      wrap_up();
    end else begin
      chk("latency", 32'(e_lat), 32'(lat));
      chk("refusal", {31'h0, e_err}, {31'h0, err});
      if (!e_err && chk_rd) chk("read data", e_rd, rd);
      if (!e_err && rd_op) begin
        chk("double error flag", 32'h0, {31'h0, dbe});
      end
    end
  endtask : judge

  task automatic cmd(input logic [1:0] op, input logic [18:0] a,
                     input logic [31:0] wd, input logic [1:0] w,
                     input int e_lat, input logic e_err,
                     input logic [31:0] e_rd);
    logic [31:0] rd;
    logic        err;
    logic        dbe;
    int          lat;
    i_fabric_requester.xfer(op, a, wd, w, rd, err, dbe, lat);
    judge(rd, err, dbe, lat, op == nvm_pkg::OP_READ, 1'b1, e_err, e_lat, e_rd);
    // Clean array: no corrected error on any accepted read
    if (op == nvm_pkg::OP_READ && !e_err) begin
      chk("single error flag", 32'h0, {31'h0, rsp_sbe_q});
    end
  endtask : cmd

  task automatic ser(input logic [14:0] blk, input logic e_err);
    logic [31:0] rd;
    logic        err;
    logic        dbe;
    int          lat;
    i_fabric_requester.jx(blk, PLAIN ^ KEY ^ {8{1'b0, blk}}, rd, err, dbe,
                          lat);
    judge(rd, err, dbe, lat, 1'b0, 1'b0, e_err, 0, 32'h0);
  endtask : ser

  // ==========================================================
  // Scenarios
  task automatic sc_erase_widths();
    cmd(nvm_pkg::OP_ERASE, 19'h0_0100, 32'h0, nvm_pkg::W32, 8, 1'b0,
        32'h0);
    cmd(nvm_pkg::OP_READ, 19'h0_0100, 32'h0, nvm_pkg::W32, 12, 1'b0,
        32'hffff_ffff);
    cmd(nvm_pkg::OP_READ, 19'h0_0102, 32'h0, nvm_pkg::W16, 12, 1'b0,
        32'h0000_ffff);
    cmd(nvm_pkg::OP_READ, 19'h0_010f, 32'h0, nvm_pkg::W8, 12, 1'b0,
        32'h0000_00ff);
  endtask : sc_erase_widths

  task automatic sc_write_program();
    cmd(nvm_pkg::OP_WRITE, 19'h0_0104, 32'hdead_beef, nvm_pkg::W32, 8, 1'b0,
        32'h0);
    cmd(nvm_pkg::OP_WRITE, 19'h0_0108, 32'h0000_005a, nvm_pkg::W8, 0, 1'b0,
        32'h0);
    cmd(nvm_pkg::OP_WRITE, 19'h0_010a, 32'h0000_1234, nvm_pkg::W16, 0, 1'b0,
        32'h0);
    cmd(nvm_pkg::OP_PROG, 19'h0_0100, 32'h0, nvm_pkg::W32, 8, 1'b0,
        32'h0);
    cmd(nvm_pkg::OP_READ, 19'h0_0104, 32'h0, nvm_pkg::W32, 12, 1'b0,
        32'hdead_beef);
  endtask : sc_write_program

  // Block buffer hits answer fast only with read-ahead on
  task automatic sc_read_ahead();
    @(posedge mclk);
    ra_en <= 1'b1;
    cmd(nvm_pkg::OP_READ, 19'h0_0108, 32'h0, nvm_pkg::W32, 2, 1'b0,
        32'h1234_ff5a);
    cmd(nvm_pkg::OP_READ, 19'h0_010b, 32'h0, nvm_pkg::W8, 2, 1'b0,
        32'h0000_0012);
    cmd(nvm_pkg::OP_READ, 19'h0_0106, 32'h0, nvm_pkg::W16, 2, 1'b0,
        32'h0000_dead);
    @(posedge mclk);
    ra_en <= 1'b0;
  endtask : sc_read_ahead

  // First address past the array is refused for read, write, erase and serial
  task automatic sc_range();
    cmd(nvm_pkg::OP_READ, 19'h4_2000, 32'h0, nvm_pkg::W32, 0, 1'b1,
        32'h0);
    cmd(nvm_pkg::OP_WRITE, 19'h4_2000, 32'h0, nvm_pkg::W32, 0, 1'b1,
        32'h0);
    cmd(nvm_pkg::OP_ERASE, 19'h4_2000, 32'h0, nvm_pkg::W32, 0, 1'b1,
        32'h0);
    ser(15'h4200, 1'b1);
  endtask : sc_range

  // Sector 1 locked: page 33 refused, page 32 still free
  task automatic sc_protect();
    @(posedge mclk);
    prot_sector <= 64'h0000_0000_0000_0002;
    cmd(nvm_pkg::OP_ERASE, 19'h0_1080, 32'h0, nvm_pkg::W32, 0, 1'b1,
        32'h0);
    ser(15'h0108, 1'b1);
    cmd(nvm_pkg::OP_ERASE, 19'h0_1000, 32'h0, nvm_pkg::W32, 8, 1'b0,
        32'h0);
    @(posedge mclk);
    prot_all <= 1'b1;
    cmd(nvm_pkg::OP_WRITE, 19'h0_0104, 32'h0, nvm_pkg::W32, 0, 1'b1,
        32'h0);
    cmd(nvm_pkg::OP_READ, 19'h0_0104, 32'h0, nvm_pkg::W32, 12, 1'b0,
        32'hdead_beef);
    @(posedge mclk);
    prot_all    <= 1'b0;
    prot_sector <= 64'h0;
  endtask : sc_protect

  // Enciphered block lands in the array as plain data
  task automatic sc_serial();
    ser(15'h0010, 1'b0);
    cmd(nvm_pkg::OP_READ, 19'h0_0100, 32'h0, nvm_pkg::W32, 12, 1'b0,
        PLAIN[31:0]);
    @(posedge mclk);
    ra_en <= 1'b1;
    cmd(nvm_pkg::OP_READ, 19'h0_010e, 32'h0, nvm_pkg::W16, 2, 1'b0,
        {16'h0000, PLAIN[127:112]});
  endtask : sc_serial

  // Low enable for three edges stretches a miss read by three
  task automatic sc_freeze();
    fork
      cmd(nvm_pkg::OP_READ, 19'h0_0104, 32'h0, nvm_pkg::W32, 15, 1'b0,
          32'hdead_beef);
      begin
        repeat (4) @(posedge mclk);
        clk_en <= 1'b0;
        repeat (3) @(posedge mclk);
        clk_en <= 1'b1;
      end
    join
  endtask : sc_freeze

  // Mid-run reset drops both buffers; the array keeps its data
  task automatic sc_reset();
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    cmd(nvm_pkg::OP_PROG, 19'h0_0100, 32'h0, nvm_pkg::W32, 0, 1'b1,
        32'h0);
    cmd(nvm_pkg::OP_READ, 19'h0_010e, 32'h0, nvm_pkg::W16, 12, 1'b0,
        {16'h0000, PLAIN[127:112]});
  endtask : sc_reset

  // ==========================================================
  // Main sequence: reset for two cycles, then the scenarios
  initial begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    sc_erase_widths();
    sc_write_program();
    sc_read_ahead();
    sc_range();
    sc_protect();
    sc_freeze();
    sc_serial();
    sc_reset();
    wrap_up();
  end
endmodule : tb_top
